// >>> hw/wrs_warm_reset_sequencer.sv
// Warm, software and watchdog reset sequencer with a classic Wishbone register slave.
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
module wrs_warm_reset_sequencer
  import wrs_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Reset pin, open drain, and power-down detect pin
  input  wire logic        reset_in_n_i,
  output logic             reset_pin_o,
  output logic             reset_pin_oe_n_o,
  input  wire logic        power_down_detect_pin_i,
  output logic             pd_pulldown_en_o,
  output logic             reset_out_n_o,
  // Configuration pins
  input  wire logic        external_access_select_n_i,
  input  wire logic [15:0] port_zero_i,
  // Core events and bus status, same clock domain
  input  wire logic        soft_reset_instr_i,
  input  wire logic        watchdog_overflow_i,
  input  wire logic        end_of_init_i,
  input  wire logic        flash_init_done_i,
  input  wire logic        ext_bus_busy_i,
  input  wire logic        ext_bus_uses_ready_i,
  input  wire logic        ext_bus_waits_done_i,
  input  wire logic        ready_n_i,
  // Sequencer outputs to the core
  output logic             internal_reset_o,
  output logic             async_reset_o,
  output logic             io_hiz_o,
  output logic             hold_cancel_o,
  output logic             bus_abort_o,
  output logic             bus_finish_o,
  output logic             port_transparent_hi_o,
  output logic             strobes_inactive_o,
  output logic             config_latch_o,
  output logic      [15:0] system_config_o,
  output logic             fetch_start_o,
  output logic      [23:0] fetch_addr_o
);

  // Synchronisers for every pin input.
  logic [1:0]  rin_sync_r;
  logic [1:0]  rpd_sync_r;
  logic [1:0]  ea_sync_r;
  logic [15:0] p0_meta_r;
  logic [15:0] p0_sync_r;

  always_ff @(posedge core_clk_i) begin
    rin_sync_r <= {rin_sync_r[0], reset_in_n_i};
    rpd_sync_r <= {rpd_sync_r[0], power_down_detect_pin_i};
    ea_sync_r  <= {ea_sync_r[0], external_access_select_n_i};
    p0_meta_r  <= port_zero_i;
    p0_sync_r  <= p0_meta_r;
  end

  // The analog filter lives outside; the synchronised level stands in for the filtered input.
  wire filtered_reset_in = rin_sync_r[1];
  wire rpd_high          = rpd_sync_r[1];
  wire internal_memory   = ea_sync_r[1];

  // Sequencer state.
  wrs_state_t  state_r;
  wrs_state_t  state_nxt;
  wrs_kind_t   kind_r;
  wrs_kind_t   kind_nxt;
  logic [9:0]  cnt_r;
  logic [9:0]  cnt_nxt;
  logic [9:0]  low_cnt_r;
  logic [1:0]  transp_cnt_r;
  logic        bidir_reset_enable_r;
  logic        bidir_arm_r;
  logic        pin_drive_ok_r;
  logic        async_r;
  logic        transparent_r;
  logic        init_phase_r;
  logic        flag_short_r;
  logic        flag_long_r;
  logic        flag_sw_r;
  logic        flag_wdt_r;
  logic [15:0] port_cfg_r;

  // Event decode.
  wire in_idle     = (state_r == WRS_IDLE);
  wire pin_low     = ~filtered_reset_in;
  wire hw_request  = pin_low && (low_cnt_r >= MIN_LOW_CNT);
  wire hw_sync     = hw_request && rpd_high;
  wire cnt_done    = (cnt_r == 10'h000);
  wire is_hw       = (kind_r == WRS_KIND_HW);
  wire bus_abortable = ext_bus_uses_ready_i && ext_bus_waits_done_i && ready_n_i;
  wire exit_ok     = filtered_reset_in && !transparent_r &&
                     (!internal_memory || flash_init_done_i);
  wire sw_degrade  = !is_hw && pin_drive_ok_r && pin_low;
  wire seq_starts  = (state_nxt == WRS_SEQ) && (state_r != WRS_SEQ);

  // Minimum low time filter on the reset input.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || filtered_reset_in) begin
      low_cnt_r <= 10'h000;
    end else if (low_cnt_r != 10'h3FF) begin
      low_cnt_r <= low_cnt_r + 10'h001;
    end
  end

  // Next state.
  always_comb begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    cnt_nxt   = cnt_done ? cnt_r : cnt_r - 10'h001;
    unique case (state_r)
      WRS_IDLE: begin
        if (hw_request) begin
          state_nxt = WRS_DETECT;
          kind_nxt  = WRS_KIND_HW;
          cnt_nxt   = HOLD_CANCEL_CNT;
        end else if (watchdog_overflow_i) begin
          state_nxt = WRS_WDT_BUS;
          kind_nxt  = WRS_KIND_WDT;
        end else if (soft_reset_instr_i) begin
          state_nxt = WRS_DETECT;
          kind_nxt  = WRS_KIND_SW;
          cnt_nxt   = HOLD_CANCEL_CNT;
        end
      end
      WRS_DETECT: begin
        if (cnt_done) begin
          state_nxt = WRS_SEQ;
          cnt_nxt   = SEQ_CNT;
        end
      end
      WRS_WDT_BUS: begin
        if (!ext_bus_busy_i || bus_abortable) begin
          state_nxt = WRS_SEQ;
          cnt_nxt   = SEQ_CNT;
        end
      end
      WRS_SEQ: begin
        if (cnt_done) begin
          state_nxt = WRS_SAMPLE;
          cnt_nxt   = SAMPLE_CNT;
        end
      end
      WRS_SAMPLE: begin
        if (cnt_done) begin
          if (sw_degrade) begin
            state_nxt = WRS_DETECT;
            kind_nxt  = WRS_KIND_HW;
            cnt_nxt   = HOLD_CANCEL_CNT;
          end else begin
            state_nxt = WRS_EXTEND;
          end
        end
      end
      WRS_EXTEND: begin
        if (exit_ok) begin
          state_nxt = WRS_EXIT;
        end
      end
      WRS_EXIT: begin
        state_nxt = WRS_IDLE;
      end
      default: begin
        state_nxt = WRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r <= WRS_IDLE;
      kind_r  <= WRS_KIND_HW;
      cnt_r   <= 10'h000;
    end else begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Bidirectional drive permission, decided at the start of the sequence.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bidir_arm_r    <= 1'b0;
      pin_drive_ok_r <= 1'b0;
    end else begin
      if (in_idle && state_nxt != WRS_IDLE) begin
        bidir_arm_r <= bidir_reset_enable_r;
      end
      if (seq_starts) begin
        pin_drive_ok_r <= bidir_arm_r && (is_hw || rpd_high);
      end else if (state_r == WRS_SEQ && !is_hw && !rpd_high) begin
        pin_drive_ok_r <= 1'b0;
      end else if (state_r == WRS_EXIT) begin
        pin_drive_ok_r <= 1'b0;
      end
    end
  end

  // Asynchronous escalation of a hardware reset; software and watchdog stay synchronous.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      async_r <= 1'b0;
    end else if (state_r == WRS_EXIT) begin
      async_r <= 1'b0;
    end else if (hw_request && !hw_sync && (is_hw || in_idle)) begin
      async_r <= 1'b1;
    end
  end

  // Port transparency for a long reset.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      transparent_r <= 1'b0;
      transp_cnt_r  <= 2'h0;
    end else if (state_r == WRS_SAMPLE && cnt_done && is_hw && pin_low) begin
      transparent_r <= 1'b1;
      transp_cnt_r  <= TRANSP_CNT;
    end else if (transparent_r && filtered_reset_in) begin
      if (transp_cnt_r == 2'h0) begin
        transparent_r <= 1'b0;
      end else begin
        transp_cnt_r <= transp_cnt_r - 2'h1;
      end
    end
  end

  // Reset source flags; cleared when a new sequence begins.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      flag_short_r <= 1'b0;
      flag_long_r  <= 1'b0;
      flag_sw_r    <= 1'b0;
      flag_wdt_r   <= 1'b0;
    end else if (in_idle && state_nxt != WRS_IDLE) begin
      flag_short_r <= 1'b0;
      flag_long_r  <= 1'b0;
      flag_sw_r    <= 1'b0;
      flag_wdt_r   <= 1'b0;
    end else if (state_r == WRS_SAMPLE && cnt_done) begin
      if (is_hw) begin
        flag_short_r <= 1'b1;
        flag_long_r  <= pin_low;
      end else if (!sw_degrade) begin
        flag_sw_r  <= (kind_r == WRS_KIND_SW);
        flag_wdt_r <= (kind_r == WRS_KIND_WDT);
      end
    end
  end

  // Configuration latch at reset exit.
  wire [15:0] soft_cfg = (port_cfg_r & SOFT_KEEP_MASK) |
                         (p0_sync_r & SOFT_LATCH_MASK) | SOFT_SET_MASK;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      port_cfg_r <= PORT_CFG_RESET;
    end else if (state_r == WRS_EXIT) begin
      port_cfg_r <= is_hw ? p0_sync_r : soft_cfg;
    end
  end

  // Init phase lasts from any reset until the end-of-init event.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !in_idle) begin
      init_phase_r <= 1'b1;
    end else if (end_of_init_i) begin
      init_phase_r <= 1'b0;
    end
  end

  // Wishbone slave: one wait state, ack falls in the cycle after it rose.
  logic        ack_r;
  logic [31:0] rdata_r;
  wire         wb_access = wb_cyc_i && wb_stb_i && !ack_r;
  wire         wr_config = wb_access && wb_we_i && wb_sel_i[0] && (wb_adr_i == ADDR_SYS_CONFIG);

  wire [31:0] status_word = {21'h000000, state_r, 2'h0, init_phase_r, async_r,
                             flag_wdt_r, flag_sw_r, flag_long_r, flag_short_r};
  wire [31:0] config_word = {28'h0000000, bidir_reset_enable_r, 3'h0};
  wire [31:0] rd_mux = (wb_adr_i == ADDR_SYS_CONFIG) ? config_word :
                       (wb_adr_i == ADDR_STATUS)     ? status_word :
                       (wb_adr_i == ADDR_PORT_CFG)   ? {16'h0000, port_cfg_r} :
                                                       32'h00000000;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r <= wb_access;
      if (wb_access && !wb_we_i) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // The enable can only be set during initialisation and is cleared by every sequence.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || state_r == WRS_EXIT) begin
      bidir_reset_enable_r <= 1'b0;
    end else if (wr_config && init_phase_r && in_idle) begin
      bidir_reset_enable_r <= wb_dat_i[BIDIR_EN_BIT];
    end
  end

  // Outputs.
  logic        cfg_pulse_r;
  logic        fetch_r;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cfg_pulse_r <= 1'b0;
      fetch_r     <= 1'b0;
    end else begin
      cfg_pulse_r <= (state_r == WRS_EXIT);
      fetch_r     <= (state_r == WRS_EXIT);
    end
  end

  assign wb_ack_o              = ack_r;
  assign wb_dat_o              = rdata_r;
  assign reset_pin_o           = 1'b0;
  assign reset_pin_oe_n_o      = !((state_r == WRS_SEQ) && pin_drive_ok_r);
  assign pd_pulldown_en_o      = pin_low;
  assign reset_out_n_o         = !init_phase_r;
  assign internal_reset_o      = !in_idle;
  assign async_reset_o         = async_r;
  assign io_hiz_o              = !in_idle;
  assign hold_cancel_o         = (state_r == WRS_DETECT);
  assign bus_abort_o           = (state_r == WRS_DETECT) ||
                                 (state_r == WRS_WDT_BUS && bus_abortable);
  assign bus_finish_o          = (state_r == WRS_WDT_BUS) && !bus_abortable;
  assign port_transparent_hi_o = transparent_r;
  assign strobes_inactive_o    = !in_idle;
  assign config_latch_o        = cfg_pulse_r;
  assign system_config_o       = port_cfg_r;
  assign fetch_start_o         = fetch_r;
  assign fetch_addr_o          = RESTART_ADDR;

endmodule : wrs_warm_reset_sequencer

// >>> hw/wrs_pkg.sv
// Constants, register map and types shared by the warm reset sequencer.
package wrs_pkg;

  // Clock and time base: one half clock period is half of the core clock period.
  localparam int CLK_PERIOD_NS   = 100;
  localparam int HALF_CLK_NS     = CLK_PERIOD_NS / 2;

  // Times in half clock periods, as specified.
  localparam int MIN_LOW_TCL     = 4;
  localparam int HOLD_CANCEL_TCL = 12;
  localparam int SEQ_TCL         = 1024;
  localparam int SAMPLE_TCL      = 8;
  localparam int TRANSP_MIN_TCL  = 3;

  // Cycle counts: least times round up, longest times round down, exact times are exact.
  localparam int MIN_LOW_CYC     = (MIN_LOW_TCL * HALF_CLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CANCEL_CYC = (HOLD_CANCEL_TCL * HALF_CLK_NS) / CLK_PERIOD_NS;
  localparam int SEQ_CYC         = (SEQ_TCL * HALF_CLK_NS) / CLK_PERIOD_NS;
  localparam int SAMPLE_CYC      = (SAMPLE_TCL * HALF_CLK_NS) / CLK_PERIOD_NS;
  localparam int TRANSP_CYC      = (TRANSP_MIN_TCL * HALF_CLK_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;

  localparam logic [9:0] MIN_LOW_CNT     = 10'(MIN_LOW_CYC - 1);
  localparam logic [9:0] HOLD_CANCEL_CNT = 10'(HOLD_CANCEL_CYC - 1);
  localparam logic [9:0] SEQ_CNT         = 10'(SEQ_CYC - 1);
  localparam logic [9:0] SAMPLE_CNT      = 10'(SAMPLE_CYC - 1);
  localparam logic [1:0] TRANSP_CNT      = 2'(TRANSP_CYC - 1);

  // Register byte addresses on the bus.
  localparam logic [7:0] ADDR_SYS_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_PORT_CFG   = 8'h08;

  // Field positions.
  localparam int BIDIR_EN_BIT   = 3;
  localparam int ST_SHORT_BIT   = 0;
  localparam int ST_LONG_BIT    = 1;
  localparam int ST_SW_BIT      = 2;
  localparam int ST_WDT_BIT     = 3;
  localparam int ST_ASYNC_BIT   = 4;
  localparam int ST_INIT_BIT    = 5;
  localparam int ST_STATE_LSB   = 8;

  // Values after reset and fixed values.
  localparam logic [15:0] PORT_CFG_RESET = 16'hFFFF;
  localparam logic [23:0] RESTART_ADDR   = 24'h000000;
  localparam logic [15:0] SOFT_KEEP_MASK = 16'hE003;
  localparam logic [15:0] SOFT_LATCH_MASK = 16'h1F00;
  localparam logic [15:0] SOFT_SET_MASK  = 16'h00FC;

  typedef enum logic [2:0] {
    WRS_IDLE    = 3'h0,
    WRS_DETECT  = 3'h1,
    WRS_SEQ     = 3'h3,
    WRS_SAMPLE  = 3'h2,
    WRS_EXTEND  = 3'h6,
    WRS_EXIT    = 3'h7,
    WRS_WDT_BUS = 3'h4
  } wrs_state_t;

  typedef enum logic [1:0] {
    WRS_KIND_HW  = 2'h0,
    WRS_KIND_SW  = 2'h1,
    WRS_KIND_WDT = 2'h2
  } wrs_kind_t;

endpackage : wrs_pkg

// >>> test/wrs_pin_model.sv
// Model of the board around the reset pin and the power-down detect capacitor.
`timescale 1ns/1ns
module wrs_pin_model (
  // Clock and bench controls
  input  wire logic core_clk_i,
  input  wire logic button_low_i,
  input  wire logic force_pd_low_i,
  input  wire logic small_cap_i,
  // Device side
  input  wire logic reset_pin_o,
  input  wire logic reset_pin_oe_n_i,
  input  wire logic pd_pulldown_en_i,
  // Pin levels
  output logic      reset_in_n_o,
  output logic      pd_pin_o
);
  logic [11:0] charge_r = 12'hFA0;

  // The pin has a pull-up, so it reads high unless a party pulls it low.
  assign reset_in_n_o = !button_low_i && (reset_pin_oe_n_i || reset_pin_o);
  assign pd_pin_o     = !force_pd_low_i && (charge_r != 12'h000);

  // The outside pull-up recharges the capacitor at once; a small one drains in a few cycles.
  always_ff @(posedge core_clk_i) begin
    if (!pd_pulldown_en_i) charge_r <= small_cap_i ? 12'h014 : 12'hFA0;
    else if (charge_r != 12'h000) charge_r <= charge_r - 12'h001;
  end
endmodule : wrs_pin_model

// >>> test/wrs_properties.sv
// Concurrent checks on the ports of the warm reset sequencer.
`timescale 1ns/1ns
module wrs_properties
  import wrs_pkg::*;
(
  // Watched ports
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        reset_in_n_i,
  input wire logic        power_down_detect_pin_i,
  input wire logic        reset_pin_o,
  input wire logic        reset_pin_oe_n_o,
  input wire logic        pd_pulldown_en_o,
  input wire logic        reset_out_n_o,
  input wire logic        internal_reset_o,
  input wire logic        io_hiz_o,
  input wire logic        strobes_inactive_o,
  input wire logic        hold_cancel_o,
  input wire logic        bus_abort_o,
  input wire logic        port_transparent_hi_o,
  input wire logic        config_latch_o,
  input wire logic        fetch_start_o,
  input wire logic [23:0] fetch_addr_o
);
  logic [10:0] oe_low_r;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || reset_pin_oe_n_o) oe_low_r <= 11'h000;
    else oe_low_r <= oe_low_r + 11'h001;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  AST_HIZ_OUT: assert property (internal_reset_o |-> io_hiz_o && strobes_inactive_o ##1 !reset_out_n_o)
    else $error("reset state outputs wrong");
  AST_HOLD_CANCEL: assert property ($rose(hold_cancel_o) |-> bus_abort_o ##[1:6] !hold_cancel_o)
    else $error("hold cancel window wrong");
  AST_SEQ_START: assert property ($fell(reset_in_n_i) && power_down_detect_pin_i && !internal_reset_o
    |-> ##[1:8] internal_reset_o)
    else $error("reset not started in time");
  AST_PIN_LEN: assert property ($rose(reset_pin_oe_n_o) |-> oe_low_r == 11'h200
    || !power_down_detect_pin_i)
    else $error("pin drive length wrong");
  AST_PIN_DRIVE: assert property (!reset_pin_oe_n_o |-> internal_reset_o && !reset_pin_o)
    else $error("pin driven outside sequence");
  AST_PD_PULL: assert property ($stable(reset_in_n_i) [*4] |-> pd_pulldown_en_o == !reset_in_n_i)
    else $error("detect pull-down wrong");
  AST_EXIT_WAIT: assert property ((internal_reset_o && !reset_in_n_i) [*3] |=> internal_reset_o)
    else $error("reset left while input low");
  AST_TRANSP_END: assert property (reset_in_n_i [*6] |-> !port_transparent_hi_o)
    else $error("transparency too long");
  AST_TRANSP_LONG: assert property ($rose(port_transparent_hi_o)
    |-> internal_reset_o && !$past(reset_in_n_i, 3))
    else $error("transparency outside long reset");
  AST_FETCH: assert property (fetch_start_o |-> config_latch_o && fetch_addr_o == RESTART_ADDR
    && $past(internal_reset_o))
    else $error("restart wrong");
endmodule : wrs_properties

bind wrs_warm_reset_sequencer wrs_properties u_props (.*);

// >>> test/tb.sv
// Self-checking bench for the warm reset sequencer.
`timescale 1ns/1ns
module tb
  import wrs_pkg::*;
;
  logic        core_clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i;
  logic        reset_in_n_i, reset_pin_o, reset_pin_oe_n_o, power_down_detect_pin_i;
  logic        pd_pulldown_en_o, reset_out_n_o, external_access_select_n_i;
  logic [15:0] port_zero_i, system_config_o, cfg_model;
  logic        soft_reset_instr_i, watchdog_overflow_i, end_of_init_i, flash_init_done_i;
  logic        ext_bus_busy_i, ext_bus_uses_ready_i, ext_bus_waits_done_i, ready_n_i;
  logic        internal_reset_o, async_reset_o, io_hiz_o, hold_cancel_o, bus_abort_o;
  logic        bus_finish_o, port_transparent_hi_o, strobes_inactive_o, config_latch_o;
  logic        fetch_start_o, button_low, force_pd, small_cap;
  logic [23:0] fetch_addr_o;
  logic [31:0] rd_q[$], mask_q[$];
  logic [15:0] cfg_q[$];
  int          n_errors = 0, comparisons = 0, seed = 47, oe_cnt = 0;

  wrs_warm_reset_sequencer u_dut (.*);
  wrs_pin_model u_pins (.core_clk_i(core_clk_i), .button_low_i(button_low),
    .force_pd_low_i(force_pd), .small_cap_i(small_cap), .reset_pin_o(reset_pin_o),
    .reset_pin_oe_n_i(reset_pin_oe_n_o), .pd_pulldown_en_i(pd_pulldown_en_o),
    .reset_in_n_o(reset_in_n_i), .pd_pin_o(power_down_detect_pin_i));

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  task automatic summarize;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task automatic check_rd(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    comparisons++;
    if ((got & m) !== (exp & m)) begin
      n_errors++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : check_rd

  task automatic check_cfg(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: config %h expected %h", $time, got, exp);
    end
  endtask : check_cfg

  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: signal %b expected %b", $time, got, exp);
    end
  endtask : check_bit

  // Results are compared in the order they appear, against the notes the drivers left.
  always @(posedge core_clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0)
      check_rd(wb_dat_o, rd_q.pop_front(), mask_q.pop_front());
    if (config_latch_o === 1'b1) check_cfg(system_config_o, cfg_q.size() ? cfg_q.pop_front() : 16'hXXXX);
    if (reset_pin_oe_n_o === 1'b0) oe_cnt++;
  end

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d;
    do begin
      @(posedge core_clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    if (wb_ack_o !== 1'b1) n_errors++;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    rd_q.push_back(exp);
    mask_q.push_back(m);
    wb(1'b0, a, 32'h0);
  endtask : rd

  // kind: 0 pin, 1 software, 2 watchdog; pdm: 0 high, 1 low, 2 drops mid-run, 3 small capacitor.
  task automatic seq(input int kind, input int hold, input logic bidir, input int pdm,
                     input logic [1:0] rdy, input logic [31:0] st, input logic [31:0] m);
    logic [15:0] p;
    logic        hw;
    int          t;
    p = 16'($random(seed));
    hw = (kind == 0) || (hold > 0);
    t = 0;
    if (bidir) wb(1'b1, ADDR_SYS_CONFIG, $random(seed) | 32'h8);
    if (bidir) rd(ADDR_SYS_CONFIG, 32'h8, 32'h8);
    @(posedge core_clk_i) end_of_init_i <= 1'b1;
    @(posedge core_clk_i) end_of_init_i <= 1'b0;
    port_zero_i <= p; small_cap <= (pdm == 3); force_pd <= (pdm == 1);
    ext_bus_busy_i <= (kind == 2); ext_bus_uses_ready_i <= rdy[1]; ready_n_i <= rdy[0];
    cfg_model = hw ? p : ((cfg_model & SOFT_KEEP_MASK) | (p & SOFT_LATCH_MASK) | SOFT_SET_MASK);
    cfg_q.push_back(cfg_model);
    repeat (4) @(posedge core_clk_i);
    check_bit(reset_out_n_o, 1'b1);
    oe_cnt = 0;
    flash_init_done_i <= 1'b0;
    case (kind)
      0: button_low <= 1'b1;
      1: soft_reset_instr_i <= 1'b1;
      default: watchdog_overflow_i <= 1'b1;
    endcase
    if (hold > 0) button_low <= 1'b1;
    @(posedge core_clk_i);
    soft_reset_instr_i <= 1'b0; watchdog_overflow_i <= 1'b0;
    if (kind == 2) begin
      while (bus_finish_o !== 1'b1 && bus_abort_o !== 1'b1 && t < 20) begin
        @(posedge core_clk_i);
        t++;
      end
      check_bit(bus_abort_o, rdy == 2'b11);
      ext_bus_busy_i <= 1'b0;
    end
    if (pdm == 2) repeat (100) @(posedge core_clk_i);
    if (pdm == 2) force_pd <= 1'b1;
    repeat (hold) @(posedge core_clk_i);
    button_low <= 1'b0;
    // Flash is held back well past the sequence so the wait for it is visible.
    repeat (700) @(posedge core_clk_i);
    check_bit(internal_reset_o, 1'b1);
    check_bit(async_reset_o, pdm == 3);
    force_pd <= 1'b0; flash_init_done_i <= 1'b1;
    t = 0;
    while (fetch_start_o !== 1'b1 && t < 100) begin
      @(posedge core_clk_i);
      t++;
    end
    check_bit(fetch_start_o, 1'b1);
    if (kind == 0 || hold == 0) check_bit(oe_cnt == 512, bidir && pdm == 0);
    check_bit(reset_out_n_o, 1'b0);
    rd(ADDR_STATUS, st, m);
    rd(ADDR_SYS_CONFIG, 32'h0, 32'h8);
    rd(ADDR_PORT_CFG, {16'h0000, cfg_model}, 32'hFFFF);
  endtask : seq

  initial begin
    rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 8'h00;
    wb_dat_i = 32'h0; wb_sel_i = 4'hF; button_low = 1'b0; force_pd = 1'b0; small_cap = 1'b0;
    external_access_select_n_i = 1'b1; port_zero_i = 16'hFFFF; soft_reset_instr_i = 1'b0;
    watchdog_overflow_i = 1'b0; end_of_init_i = 1'b0; flash_init_done_i = 1'b1;
    ext_bus_busy_i = 1'b0; ext_bus_uses_ready_i = 1'b0; ext_bus_waits_done_i = 1'b1;
    ready_n_i = 1'b0; cfg_model = PORT_CFG_RESET;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(ADDR_STATUS, 32'h0, 32'h1F);
    rd(ADDR_PORT_CFG, {16'h0000, PORT_CFG_RESET}, 32'hFFFF);
    rd(8'h0C, 32'h0, 32'hFFFFFFFF);
    seq(0, 3, 1'b1, 0, 2'b00, 32'h1, 32'hF);
    seq(0, 700, 1'b0, 0, 2'b00, 32'h3, 32'hF);
    seq(1, 0, 1'b1, 0, 2'b00, 32'h4, 32'hE);
    seq(1, 0, 1'b1, 2, 2'b00, 32'h4, 32'hE);
    seq(2, 0, 1'b1, 1, 2'b11, 32'h8, 32'hE);
    seq(2, 0, 1'b0, 0, 2'b01, 32'h8, 32'hE);
    seq(1, 700, 1'b1, 0, 2'b00, 32'h1, 32'hF);
    seq(0, 300, 1'b0, 3, 2'b00, 32'h0, 32'h0);
    summarize();
  end

  initial begin
    repeat (40000) @(posedge core_clk_i);
    n_errors++;
    summarize();
  end
endmodule : tb
